// ===== pin_output_mux_test.sv
`timescale 1ns/10ps
`default_nettype none
module pin_output_mux_test;
   import pmx_pkg::*;
   logic        clk, arst_n, reg_wr, reg_rd, reg_rvalid;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
   pmx_rx_src_t rx0_src, rx1_src;
   logic [1:0]  rx_port_en;
   logic [6:0]  pin_in, pin_out, pin_oe, pin_in_qual, ext_lvl, ext_en;
   int          err_count, num_checks, p, b;

   pmx_pin_output_mux #(.NUM_PINS(7)) i_dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .rx0_src(rx0_src), .rx1_src(rx1_src), .rx_port_en(rx_port_en), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_qual(pin_in_qual));
   pmx_pin_reader i_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .ext_en(ext_en),
      .pin_lvl(pin_in));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // strobes last exactly one cycle, so back to back calls never overlap
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      check("rvalid", 8'h01, {7'h00, reg_rvalid});
      check("rdata", exp, reg_rdata);
   endtask

   // one more edge lands the registered pin after a write or a source change
   task automatic pchk(input int i, input logic oe, input logic out);
      @(negedge clk);
      check("pin", {6'h00, oe, out}, {6'h00, pin_oe[i], pin_out[i]});
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // the whole sequence needs well under 1000 cycles
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end

   initial begin
      {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, rx0_src, rx1_src, rx_port_en, ext_lvl, ext_en} = '0;
      err_count = 0;
      num_checks = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      for (int i = 0; i < 7; i++) rd(OFS_CTRL0 + 8'(i), RST_CTRL);
      rd(OFS_INPUT_CTL, RST_INPUT_CTL);
      check("oe", 8'h00, {1'b0, pin_oe});
      wr(OFS_INPUT_CTL, 8'hff);
      rd(OFS_INPUT_CTL, 8'h7f);
      @(negedge clk);
      check("rdata hold", 8'h7f, reg_rdata);
      check("rvalid", 8'h00, {7'h00, reg_rvalid});
      for (int i = 0; i < 7; i++) wr(OFS_CTRL0 + 8'(i), {3'(i), 3'h7, 2'h2});
      for (int i = 0; i < 7; i++) rd(OFS_CTRL0 + 8'(i), {3'(i), 3'h7, 2'h2});
      pchk(6, 1'b0, 1'b0);
      wr(8'h17, 8'hff);
      rd(8'h17, 8'h00);
      $display("done registers");
      for (int g = 0; g < 2; g++) begin
         for (int f = 0; f < 8; f++) begin
            p = (f + g) % 7;
            b = (f < 4) ? 4 + f : 7 - f;
            v = 8'h01 << b;
            rx0_src = g ? ~v : v;
            rx1_src = g ? v : ~v;
            wr(OFS_CTRL0 + 8'(p), {3'(f), 3'(g), f[0], 1'b1});
            pchk(p, 1'b1, 1'b1);
            rx0_src = ~rx0_src;
            rx1_src = ~rx1_src;
            pchk(p, 1'b1, 1'b0);
            wr(OFS_CTRL0 + 8'(p), {3'(f), 3'(g), ~f[0], 1'b1});
            pchk(p, 1'b1, 1'b0);
         end
      end
      $display("done groups");
      wr(OFS_CTRL0 + 8'h3, {FN_DEV_LEVEL, GRP_DEV, 2'h3});
      pchk(3, 1'b1, 1'b1);
      wr(OFS_CTRL0 + 8'h3, {FN_DEV_LEVEL, GRP_DEV, 2'h1});
      pchk(3, 1'b1, 1'b0);
      wr(OFS_CTRL0 + 8'h3, {FN_DEV_LEVEL, GRP_DEV, 2'h2});
      pchk(3, 1'b0, 1'b0);
      wr(OFS_CTRL0 + 8'h3, {FN_DEV_LOCK_OR, GRP_DEV, 2'h1});
      for (int k = 0; k < 16; k++) begin
         rx0_src.lock = k[0];
         rx1_src.lock = k[1];
         rx_port_en = 2'(k >> 2);
         pchk(3, 1'b1, (k[0] & k[2]) | (k[1] & k[3]));
      end
      // reserved codes are programmed here on purpose
      wr(OFS_CTRL0 + 8'h3, {3'h0, 3'h2, 2'h3});
      pchk(3, 1'b0, 1'b0);
      wr(OFS_CTRL0 + 8'h3, {3'h2, GRP_DEV, 2'h3});
      pchk(3, 1'b0, 1'b0);
      $display("done status group");
      for (int i = 0; i < 7; i++) wr(OFS_CTRL0 + 8'(i), 8'h00);
      wr(OFS_CTRL0, {FN_DEV_LEVEL, GRP_DEV, 2'h3});
      ext_lvl = 7'h2a;
      ext_en = 7'h7e;
      wr(OFS_PIN_STS, 8'h00);
      rd(OFS_PIN_STS, 8'h2b);
      check("qual", 8'h00, {1'b0, pin_in_qual});
      // pin 0 stays input-disabled while it drives, as software must keep it
      wr(OFS_INPUT_CTL, 8'h0b);
      @(negedge clk);
      check("qual", 8'h20, {1'b0, pin_in_qual});
      rd(OFS_PIN_STS, 8'h2b);
      $display("done pin levels");
      report_and_stop;
   end
endmodule
`default_nettype wire

// ===== pmx_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_mux
   import pmx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire pmx_ctrl_t   ctrl,
   input  wire pmx_rx_src_t rx0_src,
   input  wire pmx_rx_src_t rx1_src,
   input  wire logic [1:0]  rx_port_en,
   output logic             pin_out_ff,
   output logic             pin_oe_ff
);

   logic nxt_pin_out;
   logic nxt_pin_oe;
   logic lock_or;

   // lock of every enabled receive port, ored
   assign lock_or = |({rx1_src.lock, rx0_src.lock} & rx_port_en); // R10

   // output select; unknown groups leave the pin floating
   always_comb begin
      nxt_pin_out = 1'b0;
      nxt_pin_oe  = 1'b0;
      if (ctrl.output_enable_bit) begin // R4
         case (ctrl.source_group_select)
            GRP_RX0: begin
               nxt_pin_oe  = 1'b1;
               nxt_pin_out = pmx_rx_pick(rx0_src, ctrl.function_select); // R5 R6 R7 R11
            end
            GRP_RX1: begin
               nxt_pin_oe  = 1'b1;
               nxt_pin_out = pmx_rx_pick(rx1_src, ctrl.function_select); // R8
            end
            GRP_DEV: begin
               if (ctrl.function_select == FN_DEV_LEVEL) begin
                  nxt_pin_oe  = 1'b1;
                  nxt_pin_out = ctrl.output_level; // R9
               end else if (ctrl.function_select == FN_DEV_LOCK_OR) begin
                  nxt_pin_oe  = 1'b1;
                  nxt_pin_out = lock_or; // R10
               end
            end
            default: nxt_pin_oe = 1'b0; // R14
         endcase
      end
   end

   // registered so the pin never glitches on a select change
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out_ff <= 1'b0;
         pin_oe_ff  <= 1'b0;
      end else begin
         pin_out_ff <= nxt_pin_out; // R15
         pin_oe_ff  <= nxt_pin_oe;
      end
   end

   a_oe_off_float: assert property (@(posedge clk) disable iff (!arst_n) // R4
      !ctrl.output_enable_bit |=> !pin_oe_ff) else $error("pin driven with enable clear");

   a_rx0_fwd_pin: assert property (@(posedge clk) disable iff (!arst_n) // R5
      ctrl.output_enable_bit && ctrl.source_group_select == GRP_RX0 && !ctrl.function_select[2]
      |=> pin_oe_ff && pin_out_ff == $past(rx0_src.fwd_pin[ctrl.function_select[1:0]]))
      else $error("rx0 forwarded pin not on output");

   a_rx0_lock_pass: assert property (@(posedge clk) disable iff (!arst_n) // R6
      ctrl.output_enable_bit && ctrl.source_group_select == GRP_RX0 && ctrl.function_select == FN_RX_PASS
      |=> pin_out_ff == $past(rx0_src.pass) && pin_oe_ff) else $error("rx0 pass not on output");

   a_rx0_video: assert property (@(posedge clk) disable iff (!arst_n) // R7
      ctrl.output_enable_bit && ctrl.source_group_select == GRP_RX0 && ctrl.function_select == FN_RX_LINE
      |=> pin_out_ff == $past(rx0_src.line_valid)) else $error("rx0 line valid not on output");

   a_rx1_lock: assert property (@(posedge clk) disable iff (!arst_n) // R8
      ctrl.output_enable_bit && ctrl.source_group_select == GRP_RX1 && ctrl.function_select == FN_RX_LOCK
      |=> pin_out_ff == $past(rx1_src.lock) && pin_oe_ff) else $error("rx1 lock not on output");

   a_level_drive: assert property (@(posedge clk) disable iff (!arst_n) // R9
      ctrl.output_enable_bit && ctrl.source_group_select == GRP_DEV && ctrl.function_select == FN_DEV_LEVEL
      |=> pin_oe_ff && pin_out_ff == $past(ctrl.output_level)) else $error("level not driven");

   a_lock_or_out: assert property (@(posedge clk) disable iff (!arst_n) // R10
      ctrl.output_enable_bit && ctrl.source_group_select == GRP_DEV && ctrl.function_select == FN_DEV_LOCK_OR
      |=> pin_out_ff == ($past(rx0_src.lock && rx_port_en[0]) || $past(rx1_src.lock && rx_port_en[1])))
      else $error("lock or wrong");

   a_level_ignored: assert property (@(posedge clk) disable iff (!arst_n) // R11
      ctrl.output_enable_bit && ctrl.source_group_select == GRP_RX1 && $stable(rx1_src)
      && $stable(ctrl.function_select) && $stable(ctrl.source_group_select) && $past(ctrl.output_enable_bit)
      |=> $stable(pin_out_ff)) else $error("level bit leaked into output");

   a_reserved_float: assert property (@(posedge clk) disable iff (!arst_n) // R14
      ctrl.source_group_select != GRP_RX0 && ctrl.source_group_select != GRP_RX1
      && ctrl.source_group_select != GRP_DEV |=> !pin_oe_ff) else $error("reserved group drives pin");

endmodule
`default_nettype wire

// ===== pmx_pin_output_mux.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1 - one control register per pin, seven consecutive
// R2 - software clears input enable before output enable
// R3 - byte holds function, group, level, enable fields
// R4 - enable bit clear leaves pin undriven
// R5 - group 0 codes 0-3 forward remote pins
// R6 - group 0 codes 4,5 give lock, pass
// R7 - group 0 codes 6,7 give frame, line valid
// R8 - group 1 same functions for receive port 1
// R9 - status group code 0 drives level bit
// R10 - status group code 1 ors enabled locks
// R11 - level bit ignored outside level function
// R12 - input disable bits, inputs enabled after reset
// R13 - status register reads every pin level
// R14 - reserved codes keep the pin undriven
// R15 - pin value registered, fixed write latency
module pmx_pin_output_mux
   import pmx_pkg::*;
#(
   parameter int NUM_PINS = 7
) (
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   output logic [7:0]               reg_rdata,
   output logic                     reg_rvalid,
   input  wire pmx_rx_src_t         rx0_src,
   input  wire pmx_rx_src_t         rx1_src,
   input  wire logic [1:0]          rx_port_en,
   input  wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0]      pin_out,
   output logic [NUM_PINS-1:0]      pin_oe,
   output logic [NUM_PINS-1:0]      pin_in_qual
);

   pmx_ctrl_t             ctrl_ff [NUM_PINS];
   pmx_ctrl_t             nxt_ctrl [NUM_PINS];
   logic [NUM_PINS-1:0]   in_dis_ff;
   logic [NUM_PINS-1:0]   nxt_in_dis;
   logic [NUM_PINS-1:0]   in_qual_ff;
   logic [NUM_PINS-1:0]   nxt_in_qual;
   logic [7:0]            rdata_ff;
   logic [7:0]            nxt_rdata;
   logic                  rvalid_ff;
   logic                  nxt_rvalid;

   // register writes: input disable byte and one control byte per pin
   always_comb begin
      nxt_ctrl   = ctrl_ff;
      nxt_in_dis = in_dis_ff;
      if (reg_wr) begin
         if (reg_addr == OFS_INPUT_CTL) begin
            nxt_in_dis = reg_wdata[NUM_PINS-1:0]; // R12
         end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
               if (reg_addr == OFS_CTRL0 + 8'(i)) begin
                  nxt_ctrl[i].function_select     = reg_wdata[FN_MSB:FN_LSB]; // R1 R3
                  nxt_ctrl[i].source_group_select = reg_wdata[GRP_MSB:GRP_LSB];
                  nxt_ctrl[i].output_level        = reg_wdata[LVL_BIT];
                  nxt_ctrl[i].output_enable_bit   = reg_wdata[OE_BIT];
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            ctrl_ff[i] <= pmx_ctrl_t'(RST_CTRL);
         end
         in_dis_ff <= RST_INPUT_CTL[NUM_PINS-1:0]; // R12
      end else begin
         ctrl_ff   <= nxt_ctrl;
         in_dis_ff <= nxt_in_dis;
      end
   end

   // reads answer one cycle later; unmapped offsets read zero
   always_comb begin
      nxt_rvalid = reg_rd;
      nxt_rdata  = rdata_ff;
      if (reg_rd) begin
         nxt_rdata = 8'h00;
         if (reg_addr == OFS_PIN_STS) begin
            nxt_rdata = 8'(pin_in); // R13
         end else if (reg_addr == OFS_INPUT_CTL) begin
            nxt_rdata = 8'(in_dis_ff);
         end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
               if (reg_addr == OFS_CTRL0 + 8'(i)) begin
                  nxt_rdata = ctrl_ff[i];
               end
            end
         end
      end
   end

   // input path to the core; a disabled pin reads low there, not in status
   assign nxt_in_qual = pin_in & ~in_dis_ff; // R12

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff   <= 8'h00;
         rvalid_ff  <= 1'b0;
         in_qual_ff <= '0;
      end else begin
         rdata_ff   <= nxt_rdata;
         rvalid_ff  <= nxt_rvalid;
         in_qual_ff <= nxt_in_qual;
      end
   end

   assign reg_rdata   = rdata_ff;
   assign reg_rvalid  = rvalid_ff;
   assign pin_in_qual = in_qual_ff;

   // one selector per pin; software sequencing of input vs output is its own job
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      pmx_pin_mux u_mux (
         .clk        (clk),
         .arst_n     (arst_n),
         .ctrl       (ctrl_ff[g]),
         .rx0_src    (rx0_src),
         .rx1_src    (rx1_src),
         .rx_port_en (rx_port_en),
         .pin_out_ff (pin_out[g]),
         .pin_oe_ff  (pin_oe[g])
      );
   end

   a_ctrl_own_pin: assert property (@(posedge clk) disable iff (!arst_n) // R1
      reg_wr && reg_addr == OFS_CTRL0 + 8'h02
      |=> ctrl_ff[2] == $past(reg_wdata) && ctrl_ff[3] == $past(ctrl_ff[3]) && ctrl_ff[1] == $past(ctrl_ff[1]))
      else $error("control write hit wrong pin");

   a_ctrl_fields: assert property (@(posedge clk) disable iff (!arst_n) // R3
      reg_wr && reg_addr == OFS_CTRL0
      |=> ctrl_ff[0].function_select == $past(reg_wdata[7:5]) && ctrl_ff[0].output_enable_bit == $past(reg_wdata[0]))
      else $error("control field layout wrong");

   a_input_dis: assert property (@(posedge clk) disable iff (!arst_n) // R12
      in_dis_ff[0] |=> !pin_in_qual[0]) else $error("disabled input reached the core");

   a_in_dis_read: assert property (@(posedge clk) disable iff (!arst_n) // R12
      reg_rd && reg_addr == OFS_INPUT_CTL |=> reg_rdata == 8'($past(in_dis_ff)))
      else $error("input disable readback wrong");

   a_read_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      !reg_rd |=> !reg_rvalid) else $error("read valid without a read");

   a_rdata_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");

   a_status_read: assert property (@(posedge clk) disable iff (!arst_n) // R13
      reg_rd && reg_addr == OFS_PIN_STS |=> reg_rvalid && reg_rdata == 8'($past(pin_in)))
      else $error("pin status read wrong");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd && (reg_addr < OFS_PIN_STS || reg_addr > OFS_CTRL6) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_write_latency: assert property (@(posedge clk) disable iff (!arst_n) // R15
      reg_wr && reg_addr == OFS_CTRL0 && !reg_wdata[OE_BIT] |=> ##1 !pin_oe[0])
      else $error("pin not released two cycles after write");

   a_level_latency: assert property (@(posedge clk) disable iff (!arst_n) // R15 R9
      reg_wr && reg_addr == OFS_CTRL0 && reg_wdata == {FN_DEV_LEVEL, GRP_DEV, 2'b11}
      ##1 !(reg_wr && reg_addr == OFS_CTRL0) |=> pin_oe[0] && pin_out[0])
      else $error("level write late");

   c_level_high:  cover property (@(posedge clk) disable iff (!arst_n) pin_oe[0] && pin_out[0]);
   c_rx1_out:     cover property (@(posedge clk) disable iff (!arst_n)
      pin_oe[1] && ctrl_ff[1].source_group_select == GRP_RX1);
   c_lock_or:     cover property (@(posedge clk) disable iff (!arst_n)
      ctrl_ff[3].source_group_select == GRP_DEV && ctrl_ff[3].function_select == FN_DEV_LOCK_OR && pin_out[3]);
   c_status_read: cover property (@(posedge clk) disable iff (!arst_n) reg_rvalid && reg_rdata != 8'h00);

   // per-pin checks, so each pin is watched in whatever role the tests give it
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_chk
      // an undriven pin never carries a stale high value
      a_pin_idle_low: assert property (@(posedge clk) disable iff (!arst_n) // R4
         !pin_oe[g] |-> !pin_out[g]) else $error("undriven pin shows high");

      a_pin_rx0_lock: assert property (@(posedge clk) disable iff (!arst_n) // R6
         ctrl_ff[g].output_enable_bit && ctrl_ff[g].source_group_select == GRP_RX0
         && ctrl_ff[g].function_select == FN_RX_LOCK
         |=> pin_oe[g] && pin_out[g] == $past(rx0_src.lock))
         else $error("rx0 lock not on pin");

      a_pin_rx0_frame: assert property (@(posedge clk) disable iff (!arst_n) // R7
         ctrl_ff[g].output_enable_bit && ctrl_ff[g].source_group_select == GRP_RX0
         && ctrl_ff[g].function_select == FN_RX_FV
         |=> pin_oe[g] && pin_out[g] == $past(rx0_src.frame_valid))
         else $error("rx0 frame valid not on pin");

      a_pin_rx1_fwd: assert property (@(posedge clk) disable iff (!arst_n) // R8
         ctrl_ff[g].output_enable_bit && ctrl_ff[g].source_group_select == GRP_RX1
         && !ctrl_ff[g].function_select[2]
         |=> pin_oe[g] && pin_out[g] == $past(rx1_src.fwd_pin[ctrl_ff[g].function_select[1:0]]))
         else $error("rx1 forwarded pin not on pin");

      a_pin_rx1_line: assert property (@(posedge clk) disable iff (!arst_n) // R8
         ctrl_ff[g].output_enable_bit && ctrl_ff[g].source_group_select == GRP_RX1
         && ctrl_ff[g].function_select == FN_RX_LINE
         |=> pin_oe[g] && pin_out[g] == $past(rx1_src.line_valid))
         else $error("rx1 line valid not on pin");

      a_pin_dev_other: assert property (@(posedge clk) disable iff (!arst_n) // R14
         ctrl_ff[g].source_group_select == GRP_DEV && ctrl_ff[g].function_select != FN_DEV_LEVEL
         && ctrl_ff[g].function_select != FN_DEV_LOCK_OR |=> !pin_oe[g])
         else $error("unsupported status function drives pin");

      // control bytes read back as written; a read in the write cycle sees the old byte
      a_ctrl_readback: assert property (@(posedge clk) disable iff (!arst_n) // R3
         reg_rd && reg_addr == OFS_CTRL0 + 8'(g) |=> reg_rdata == $past(ctrl_ff[g]))
         else $error("control byte readback wrong");

      // an enabled input path follows its pad one cycle late
      a_in_enabled: assert property (@(posedge clk) disable iff (!arst_n) // R12
         !in_dis_ff[g] |=> pin_in_qual[g] == $past(pin_in[g]))
         else $error("enabled input path wrong");
   end

endmodule
`default_nettype wire

// ===== pmx_pin_reader.sv
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_reader (
   input  wire logic [6:0] pin_out,
   input  wire logic [6:0] pin_oe,
   input  wire logic [6:0] ext_lvl,
   input  wire logic [6:0] ext_en,
   output logic [6:0]      pin_lvl
);
   // pad level: device drive wins, else outside driver, else the internal pull-down
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_lvl[i] : 1'b0);
      end
   end
endmodule
`default_nettype wire

// ===== pmx_pkg.sv
package pmx_pkg;

   // register offsets on the control bus
   localparam logic [7:0] OFS_PIN_STS   = 8'h0e;
   localparam logic [7:0] OFS_INPUT_CTL = 8'h0f;
   localparam logic [7:0] OFS_CTRL0     = 8'h10;
   localparam logic [7:0] OFS_CTRL6     = 8'h16;

   // reset values
   localparam logic [7:0] RST_CTRL      = 8'h00;
   localparam logic [7:0] RST_INPUT_CTL = 8'h00;

   // field positions inside a pin output control byte
   localparam int FN_MSB  = 7;
   localparam int FN_LSB  = 5;
   localparam int GRP_MSB = 4;
   localparam int GRP_LSB = 2;
   localparam int LVL_BIT = 1;
   localparam int OE_BIT  = 0;

   // source groups
   localparam logic [2:0] GRP_RX0 = 3'h0;
   localparam logic [2:0] GRP_RX1 = 3'h1;
   localparam logic [2:0] GRP_DEV = 3'h4;

   // function codes within a receive port group
   localparam logic [2:0] FN_RX_LOCK = 3'h4;
   localparam logic [2:0] FN_RX_PASS = 3'h5;
   localparam logic [2:0] FN_RX_FV   = 3'h6;
   localparam logic [2:0] FN_RX_LINE = 3'h7;

   // function codes within the device status group
   localparam logic [2:0] FN_DEV_LEVEL   = 3'h0;
   localparam logic [2:0] FN_DEV_LOCK_OR = 3'h1;

   // cycles from a control write to the pin
   localparam int PIN_WR_LAT = 2;

   typedef struct packed {
      logic [2:0] function_select;
      logic [2:0] source_group_select;
      logic       output_level;
      logic       output_enable_bit;
   } pmx_ctrl_t;

   typedef struct packed {
      logic [3:0] fwd_pin;
      logic       lock;
      logic       pass;
      logic       frame_valid;
      logic       line_valid;
   } pmx_rx_src_t;

   // one receive port's signal picked by a function code
   function automatic logic pmx_rx_pick(input pmx_rx_src_t s, input logic [2:0] fn);
      logic v;
      v = 1'b0;
      case (fn)
         FN_RX_LOCK: v = s.lock;
         FN_RX_PASS: v = s.pass;
         FN_RX_FV:   v = s.frame_valid;
         FN_RX_LINE: v = s.line_valid;
         default:    v = s.fwd_pin[fn[1:0]];
      endcase
      return v;
   endfunction

endpackage
